// ==== src/rate_comp_pkg.sv ====
// Shared constants and types of the rate compensation block
package rate_comp_pkg;
	// Data widths
	localparam int RATE_W = 24;
	localparam int TEMP_W = 16;
	localparam int ACC_W = 48;
	localparam int DIV_W = 80;
	localparam int NVM_AW = 7;
	localparam int NSYS = 14;
	localparam int SLOT_W = 5;
	// Register indexes; byte offset is four times the index
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_SLOT = 5'h01;
	localparam logic [4:0] IDX_SF4 = 5'h02;
	localparam logic [4:0] IDX_SF0 = 5'h06;
	localparam logic [4:0] IDX_B4 = 5'h07;
	localparam logic [4:0] IDX_B0 = 5'h0b;
	localparam logic [4:0] IDX_MID_TEMP_POINT = 5'h0c;
	localparam logic [4:0] IDX_TCAL = 5'h0d;
	localparam logic [4:0] IDX_COMMIT = 5'h0e;
	localparam logic [4:0] IDX_STATUS = 5'h0f;
	localparam logic [4:0] IDX_RATE = 5'h10;
	localparam logic [4:0] IDX_TEMP = 5'h11;
	// Field positions
	localparam int CTRL_RATE_SEL = 0;
	localparam int CTRL_TEMP_SEL = 1;
	localparam int TCAL_GAIN_LSB = 4;
	localparam int TCAL_OFS_LSB = 18;
	localparam int TCAL_FLD_W = 14;
	// Writable masks
	localparam logic [31:0] MASK_CTRL = 32'h0000_0003;
	localparam logic [31:0] MASK_SLOT = 32'h0000_001f;
	localparam logic [31:0] MASK_TCAL = 32'hffff_fff0;
	// Coefficient widths, scale orders 4..0, bias orders 4..0, mid point
	localparam int W_SF4 = 19;
	localparam int W_SF3 = 20;
	localparam int W_SF2 = 21;
	localparam int W_SF1 = 30;
	localparam int W_SF0 = 31;
	localparam int W_B4 = 19;
	localparam int W_B3 = 20;
	localparam int W_B2 = 20;
	localparam int W_B1 = 30;
	localparam int W_B0 = 24;
	localparam int W_MID_TEMP_POINT = 20;
	// Reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0001;
	localparam logic [31:0] RST_SF0 = 32'h0800_0000;
	localparam logic [31:0] RST_TCAL = 32'h0000_8000;
	// Fixed-point shifts of the polynomial datapath
	localparam int TEMP_X_SH = 6;
	localparam int POW_SH = 16;
	localparam int B_SH1 = 20;
	localparam int B_SH2 = 16;
	localparam int B_SH3 = 21;
	localparam int B_SH4 = 25;
	localparam int S_SH1 = 19;
	localparam int S_SH2 = 12;
	localparam int S_SH3 = 13;
	localparam int S_SH4 = 17;
	localparam int DIV_SH = 27;
	localparam int GAIN_SH = 11;
	// Output scales, folded into the stored coefficients
	localparam int RATE_OUT_SCALE = 10000;
	localparam int TEMP_OUT_SCALE = 85;
	// Slot counter
	localparam logic [SLOT_W-1:0] SLOT_FULL = 5'h1f;
	localparam logic [NVM_AW-1:0] NVM_CNT_ADDR = 7'h71;
	localparam logic [4:0] LOAD_LAST = 5'h10;
	// Sequencer states
	typedef enum logic [3:0] {
		ST_LOAD = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_POLY = 4'b0100,
		ST_DIV = 4'b1000
	} state_e;
endpackage

// ==== src/rate_nvm_store.sv ====
// Multi-program coefficient memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rate_nvm_store #(
	parameter int W = 32,
	parameter int AW = 7
) (
	// Clock and power-on erase
	input wire logic clk,
	input wire logic por_n,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] mem;
		logic [W-1:0] rdata;
	} nvm_s;
	nvm_s r_reg, r_next;

	// Read first: returns the stored word, not one written in the same cycle
	always_comb begin
		r_next = r_reg;
		if (we) begin
			r_next.mem[waddr] = wdata;
		end
		r_next.rdata = r_reg.mem[raddr];
	end

	// Contents survive the block reset; only power-on erases them
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata = r_reg.rdata;
endmodule // rate_nvm_store
`default_nettype wire

// ==== src/rate_temp_compensation_nvm.sv ====
// Rate thermal compensation datapath with multi-program coefficient store
// Functional notes
// - Compensate the filtered rate using temperature and stored coefficients.
// - Output equals raw minus bias over scale term, times output scale.
// - Bias is a fourth-degree polynomial of the temperature offset.
// - Scale term is a fourth-degree polynomial of the temperature offset.
// - Offset variable is raw temperature times 64 minus mid point.
// - Scale coefficients are signed, prescaled by powers of two over scale.
// - Bias coefficients are signed, prescaled; constant bias stored unscaled.
// - Slot counter is five-bit thermometer; all ones means no more programming.
// - At most four reprogrammings beyond the factory one.
// - Committing is irreversible; earlier coefficients become unreachable.
// - New coefficients ignored unless slot counter was updated.
// - Committed coefficients take effect only after reset reload.
// - Zero coefficients with scale constant 0x0800_0000 give raw output.
// - Rate calibration select at 0 passes the raw rate.
// - Calibrated temperature is gain times raw minus offset.
// - Temperature select at 1 gives calibrated output; default 0.
`timescale 1ns/1ps
`default_nettype none
module rate_temp_compensation_nvm
	import rate_comp_pkg::*;
(
	// Clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic nvm_por_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Filtered sensor words, same clock domain
	input wire logic [rate_comp_pkg::RATE_W-1:0] raw_rate,
	input wire logic raw_rate_valid,
	input wire logic [rate_comp_pkg::TEMP_W-1:0] raw_temp,
	// Compensated outputs
	output logic [rate_comp_pkg::RATE_W-1:0] rate_out,
	output logic rate_out_valid,
	output logic [rate_comp_pkg::TEMP_W-1:0] temp_out
);
	import rate_comp_pkg::*;

	typedef struct packed {
		state_e state;
		logic [4:0] lidx;
		logic loaded;
		logic [NSYS-1:0][31:0] sys;
		logic [SLOT_W-1:0] nvm_cnt;
		logic [2:0] step;
		logic signed [RATE_W-1:0] raw;
		logic signed [ACC_W-1:0] x;
		logic signed [ACC_W-1:0] pow;
		logic signed [ACC_W-1:0] bias;
		logic signed [ACC_W-1:0] sf;
		logic [DIV_W-1:0] num;
		logic [ACC_W-1:0] den;
		logic [ACC_W:0] rem;
		logic [DIV_W-1:0] quot;
		logic [6:0] dcnt;
		logic neg;
		logic nvm_we;
		logic [NVM_AW-1:0] nvm_waddr;
		logic [31:0] nvm_wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [RATE_W-1:0] rate_out;
		logic rate_v;
		logic [TEMP_W-1:0] temp_out;
	} regs_s;

	regs_s r_reg, r_next;
	logic [NVM_AW-1:0] nvm_raddr;
	logic [31:0] nvm_rdata;

	// Writable bits of each system register
	function automatic logic [31:0] wmask(input logic [4:0] idx);
		int w;
		w = 32;
		unique case (idx)
			IDX_CTRL: return MASK_CTRL;
			IDX_SLOT: return MASK_SLOT;
			IDX_TCAL: return MASK_TCAL;
			5'h02: w = W_SF4;
			5'h03: w = W_SF3;
			5'h04: w = W_SF2;
			5'h05: w = W_SF1;
			5'h06: w = W_SF0;
			5'h07: w = W_B4;
			5'h08: w = W_B3;
			5'h09: w = W_B2;
			5'h0a: w = W_B1;
			5'h0b: w = W_B0;
			5'h0c: w = W_MID_TEMP_POINT;
			default: return 32'h0000_0000;
		endcase
		return 32'hffff_ffff >> (32 - w);
	endfunction

	// Sign-extend a stored coefficient to accumulator width
	function automatic logic signed [ACC_W-1:0] sext(input logic [4:0] idx, input logic [31:0] v);
		logic signed [ACC_W-1:0] t;
		int lz;
		t = $signed({v, 16'h0000});
		lz = 32 - $countones(wmask(idx));
		return (t <<< lz) >>> (16 + lz);
	endfunction

	// Fixed-point product with arithmetic shift
	function automatic logic signed [ACC_W-1:0] mul_sh(input logic signed [ACC_W-1:0] a,
		input logic signed [ACC_W-1:0] b, input int sh);
		logic signed [2*ACC_W-1:0] p;
		p = a * b;
		p = p >>> sh;
		return p[ACC_W-1:0];
	endfunction

	// Memory location of a register in a slot; the counter has its own word
	function automatic logic [NVM_AW-1:0] nvm_addr(input logic [4:0] idx, input logic [2:0] slot);
		if (idx == IDX_SLOT) begin
			return NVM_CNT_ADDR;
		end
		return {slot, idx[3:0]};
	endfunction

	// Programmings recorded by a thermometer count
	function automatic logic [2:0] slot_used(input logic [SLOT_W-1:0] c);
		return 3'($countones(c));
	endfunction

	// Signed saturation of the quotient magnitude
	function automatic logic [RATE_W-1:0] sat_rate(input logic [DIV_W-1:0] mag, input logic neg);
		logic [DIV_W-1:0] lim;
		lim = DIV_W'(1) << (RATE_W - 1);
		if (!neg && mag >= lim) begin
			return {1'b0, {(RATE_W-1){1'b1}}};
		end
		if (neg && mag > lim) begin
			return {1'b1, {(RATE_W-1){1'b0}}};
		end
		return neg ? RATE_W'(-mag) : mag[RATE_W-1:0];
	endfunction

	// Counter word first, so the latest committed slot is known before any coefficient
	always_comb begin
		nvm_raddr = (r_reg.lidx == 5'h00) ? NVM_CNT_ADDR
			: nvm_addr(5'(r_reg.lidx - 5'h02), slot_used(r_reg.nvm_cnt) - 3'h1);
	end

	// Register file, reload sequencer and datapath
	always_comb begin
		logic [4:0] idx;
		logic [4:0] cidx;
		logic [4:0] kidx;
		logic wr_ok;
		logic [31:0] rd;
		logic signed [ACC_W-1:0] nb;
		logic signed [ACC_W-1:0] ns;
		logic signed [ACC_W:0] diff;
		logic [ACC_W:0] rem_s;
		logic qbit;
		logic [DIV_W-1:0] q_n;
		logic signed [ACC_W-1:0] tprod;
		idx = paddr[6:2];
		cidx = pwdata[4:0];
		kidx = 5'(r_reg.lidx - 5'h03);
		wr_ok = 1'b0;
		rd = 32'h0000_0000;
		nb = '0;
		ns = '0;
		diff = '0;
		rem_s = '0;
		qbit = 1'b0;
		q_n = '0;
		tprod = '0;
		r_next = r_reg;
		r_next.pready = 1'b0;
		r_next.prdata = 32'h0000_0000;
		r_next.pslverr = 1'b0;
		r_next.rate_v = 1'b0;
		r_next.nvm_we = 1'b0;

		// Read mux
		if (idx < 5'(NSYS)) begin
			rd = r_reg.sys[idx];
		end else if (idx == IDX_STATUS) begin
			rd = {19'h0, r_reg.nvm_cnt, r_reg.loaded, 3'h0, r_reg.state};
		end else if (idx == IDX_RATE) begin
			rd = 32'($signed(r_reg.rate_out));
		end else if (idx == IDX_TEMP) begin
			rd = 32'($signed(r_reg.temp_out));
		end

		// Legal writes; counter commit must be exactly one step further
		if (r_reg.state == ST_LOAD || paddr[1:0] != 2'b00) begin
			wr_ok = 1'b0;
		end else if (idx < 5'(NSYS)) begin
			wr_ok = 1'b1;
		end else if (idx == IDX_COMMIT) begin
			if (r_reg.nvm_cnt == SLOT_FULL || cidx >= 5'(NSYS)) begin
				wr_ok = 1'b0;
			end else if (cidx == IDX_SLOT) begin
				wr_ok = r_reg.sys[IDX_SLOT][SLOT_W-1:0] == {r_reg.nvm_cnt[SLOT_W-2:0], 1'b1};
			end else begin
				wr_ok = 1'b1;
			end
		end

		// Zero-wait slave: answer registered in the setup cycle
		if (psel && !penable) begin
			r_next.pready = 1'b1;
			r_next.prdata = pwrite ? 32'h0000_0000 : rd;
			if (pwrite) begin
				r_next.pslverr = !wr_ok;
			end else begin
				r_next.pslverr = idx > IDX_TEMP || paddr[1:0] != 2'b00;
			end
		end

		// Write takes effect at the access edge
		if (psel && penable && r_reg.pready && pwrite && !r_reg.pslverr) begin
			if (idx < 5'(NSYS)) begin
				r_next.sys[idx] = pwdata & wmask(idx);
			end else begin
				// New set goes to the next unused slot; old slot stays untouched
				r_next.nvm_we = 1'b1;
				r_next.nvm_waddr = nvm_addr(cidx, slot_used(r_reg.nvm_cnt));
				r_next.nvm_wdata = r_reg.sys[cidx];
				if (cidx == IDX_SLOT) begin
					r_next.nvm_cnt = r_reg.sys[IDX_SLOT][SLOT_W-1:0];
				end
			end
		end

		// Temperature path, raw or first-order calibrated
		tprod = $signed(raw_temp) * $signed({1'b0, r_reg.sys[IDX_TCAL][TCAL_GAIN_LSB +: TCAL_FLD_W]});
		if (r_reg.sys[IDX_CTRL][CTRL_TEMP_SEL]) begin
			r_next.temp_out = TEMP_W'((tprod >>> GAIN_SH)
				- $signed({1'b0, r_reg.sys[IDX_TCAL][TCAL_OFS_LSB +: TCAL_FLD_W]}));
		end else begin
			r_next.temp_out = raw_temp;
		end

		unique case (r_reg.state)
			ST_LOAD: begin
				// Counter word first, then every register of the active slot
				r_next.lidx = r_reg.lidx + 5'h01;
				if (r_reg.lidx == 5'h01) begin
					r_next.nvm_cnt = nvm_rdata[SLOT_W-1:0];
				end
				if (r_reg.lidx >= 5'h03 && r_reg.nvm_cnt != '0) begin
					r_next.sys[kidx] = nvm_rdata & wmask(kidx);
				end
				if (r_reg.lidx == LOAD_LAST) begin
					r_next.state = ST_IDLE;
					r_next.loaded = 1'b1;
				end
			end
			ST_IDLE: begin
				if (raw_rate_valid) begin
					if (!r_reg.sys[IDX_CTRL][CTRL_RATE_SEL]) begin
						r_next.rate_out = raw_rate;
						r_next.rate_v = 1'b1;
					end else begin
						// Filtered word enters the compensation pipeline
						r_next.raw = $signed(raw_rate);
						r_next.x = ACC_W'($signed(raw_temp) <<< TEMP_X_SH)
							- $signed({1'b0, r_reg.sys[IDX_MID_TEMP_POINT][W_MID_TEMP_POINT-1:0]});
						r_next.pow = r_next.x;
						r_next.bias = sext(IDX_B0, r_reg.sys[IDX_B0]);
						r_next.sf = sext(IDX_SF0, r_reg.sys[IDX_SF0]);
						r_next.step = 3'h1;
						r_next.state = ST_POLY;
					end
				end
			end
			ST_POLY: begin
				// One order per cycle; powers kept prescaled to bound width
				unique case (r_reg.step)
					3'h1: begin
						nb = mul_sh(sext(5'h0a, r_reg.sys[5'h0a]), r_reg.pow, B_SH1);
						ns = mul_sh(sext(5'h05, r_reg.sys[5'h05]), r_reg.pow, S_SH1);
					end
					3'h2: begin
						nb = mul_sh(sext(5'h09, r_reg.sys[5'h09]), r_reg.pow, B_SH2);
						ns = mul_sh(sext(5'h04, r_reg.sys[5'h04]), r_reg.pow, S_SH2);
					end
					3'h3: begin
						nb = mul_sh(sext(5'h08, r_reg.sys[5'h08]), r_reg.pow, B_SH3);
						ns = mul_sh(sext(5'h03, r_reg.sys[5'h03]), r_reg.pow, S_SH3);
					end
					default: begin
						nb = mul_sh(sext(IDX_B4, r_reg.sys[IDX_B4]), r_reg.pow, B_SH4);
						ns = mul_sh(sext(IDX_SF4, r_reg.sys[IDX_SF4]), r_reg.pow, S_SH4);
					end
				endcase
				r_next.bias = r_reg.bias + nb;
				r_next.sf = r_reg.sf + ns;
				r_next.pow = mul_sh(r_reg.pow, r_reg.x, POW_SH);
				r_next.step = r_reg.step + 3'h1;
				if (r_reg.step == 3'h4) begin
					// Sign-magnitude setup of (raw - bias) * 2^27 / scale
					diff = (ACC_W+1)'(r_reg.raw) - (ACC_W+1)'(r_next.bias);
					r_next.neg = diff[ACC_W] ^ r_next.sf[ACC_W-1];
					r_next.num = DIV_W'(diff[ACC_W] ? -diff : diff) << DIV_SH;
					r_next.den = r_next.sf[ACC_W-1] ? ACC_W'(-r_next.sf) : ACC_W'(r_next.sf);
					r_next.rem = '0;
					r_next.quot = '0;
					r_next.dcnt = '0;
					r_next.state = ST_DIV;
				end
			end
			ST_DIV: begin
				// Restoring divider, one quotient bit per cycle
				rem_s = {r_reg.rem[ACC_W-1:0], r_reg.num[DIV_W-1]};
				if (rem_s >= {1'b0, r_reg.den}) begin
					rem_s = rem_s - {1'b0, r_reg.den};
					qbit = 1'b1;
				end
				q_n = {r_reg.quot[DIV_W-2:0], qbit};
				r_next.rem = rem_s;
				r_next.quot = q_n;
				r_next.num = r_reg.num << 1;
				r_next.dcnt = r_reg.dcnt + 7'h01;
				if (r_reg.dcnt == 7'(DIV_W - 1)) begin
					// Zero scale term saturates, no trap
					r_next.rate_out = sat_rate(q_n, r_reg.neg);
					r_next.rate_v = 1'b1;
					r_next.state = ST_IDLE;
				end
			end
		endcase
	end

	// Coefficient store, written one cycle after the commit write
	rate_nvm_store #(
		.W(32),
		.AW(NVM_AW)
	) u_store (
		.clk(pclk),
		.por_n(nvm_por_n),
		.we(r_reg.nvm_we),
		.waddr(r_reg.nvm_waddr),
		.wdata(r_reg.nvm_wdata),
		.raddr(nvm_raddr),
		.rdata(nvm_rdata)
	);

	// State register; defaults until the reload overwrites them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.state <= ST_LOAD;
			r_reg.sys[IDX_CTRL] <= RST_CTRL;
			r_reg.sys[IDX_SF0] <= RST_SF0;
			r_reg.sys[IDX_TCAL] <= RST_TCAL;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign rate_out = r_reg.rate_out;
	assign rate_out_valid = r_reg.rate_v;
	assign temp_out = r_reg.temp_out;
endmodule // rate_temp_compensation_nvm
`default_nettype wire

// ==== verification/rate_comp_assertions.sv ====
// Port checker for the rate compensation block
`timescale 1ns/1ps
`default_nettype none
module rate_comp_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sensor words
	input wire logic [23:0] raw_rate,
	input wire logic raw_rate_valid,
	input wire logic [15:0] raw_temp,
	input wire logic [23:0] rate_out,
	input wire logic rate_out_valid,
	input wire logic [15:0] temp_out
);
	logic [1:0] ctrl_mirror;
	// Select bits seen on the bus; reload keeps them as the host commits them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_mirror <= 2'h1;
		else if (psel && penable && pready && pwrite && !pslverr && paddr == 8'h00)
			ctrl_mirror <= pwdata[1:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_read_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
	a_raw_rate_pass: assert property (rate_out_valid && !ctrl_mirror[0] |-> $past(raw_rate_valid) && rate_out == $past(raw_rate)) else $error("raw rate not passed");
	a_comp_latency: assert property (rate_out_valid && ctrl_mirror[0] |-> $past(raw_rate_valid, 85)) else $error("result latency wrong");
	a_out_hold: assert property (!rate_out_valid |-> $stable(rate_out)) else $error("rate moved without pulse");
	a_temp_raw: assert property (presetn && !ctrl_mirror[1] |=> temp_out == $past(raw_temp)) else $error("raw temperature not passed");
	c_comp_result: cover property (rate_out_valid && ctrl_mirror[0]);
	c_raw_result: cover property (rate_out_valid && !ctrl_mirror[0]);
	c_refused: cover property (pready && pslverr);
endmodule // rate_comp_checker
bind rate_temp_compensation_nvm rate_comp_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .raw_rate, .raw_rate_valid, .raw_temp, .rate_out, .rate_out_valid, .temp_out);
`default_nettype wire

// ==== verification/rate_comp_host.sv ====
// Host model: bus master and coefficient programming steps
`timescale 1ns/1ps
`default_nettype none
module rate_comp_host (
	// Clock
	input wire logic pclk,
	// Bus master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Request held until ready is sampled; address and data scrambled once released
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (!pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	// System register first, store second
	task automatic commit_reg(input logic [4:0] idx, input logic [31:0] v, output logic err);
		logic [31:0] rd;
		logic e;
		xfer(1'b1, {1'b0, idx, 2'b00}, v, rd, e);
		xfer(1'b1, 8'h38, {27'h0, idx}, rd, err);
		err = err | e;
	endtask
	// Scale, bias, mid point, then temperature gains and selects
	task automatic program_all(input logic [31:0] v [14], output logic err);
		logic e;
		err = 1'b0;
		for (int i = 2; i < 15; i++) begin
			commit_reg(i == 14 ? 5'h00 : 5'(i), v[i % 14], e);
			err = err | e;
		end
	endtask
	// Counter read first, then one thermometer step committed
	task automatic step_slot(output logic [4:0] nxt, output logic err);
		logic [31:0] rd;
		logic e;
		xfer(1'b0, 8'h04, 32'h0, rd, e);
		nxt = {rd[3:0], 1'b1};
		commit_reg(5'h01, {27'h0, nxt}, err);
	endtask
endmodule // rate_comp_host
`default_nettype wire

// ==== verification/rate_temp_compensation_nvm_test.sv ====
// Self-checking bench for the rate compensation block
`timescale 1ns/1ps
`default_nettype none
module rate_temp_compensation_nvm_test;
	import rate_comp_pkg::*;
	logic pclk, presetn, nvm_por_n, psel, penable, pwrite, pready, pslverr, raw_rate_valid, rate_out_valid, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v [14];
	logic [23:0] raw_rate, rate_out;
	logic [15:0] raw_temp, temp_out;
	logic [4:0] slot;
	int miscompares, cmp_count, n;
	longint r, g, o, b0, sf0;
	rate_temp_compensation_nvm dut (.pclk, .presetn, .nvm_por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .raw_rate, .raw_rate_valid, .raw_temp, .rate_out, .rate_out_valid, .temp_out);
	rate_comp_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	// Free-running clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic req(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic exp);
		host.xfer(wr, a, d, rd, err);
		chk("refusal", {31'h0, exp}, {31'h0, err});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		req(1'b0, a, 32'h0, 1'b0);
		chk("read data", exp, rd);
	endtask
	// Reset with the store kept; waits for the reload to end
	task automatic reboot;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		do begin
			host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
			n++;
		end while (rd[3:0] !== 4'h2 && n < 40);
		chk("load state", 32'h2, {28'h0, rd[3:0]});
	endtask
	// Latency counted from the taking edge to the result pulse
	task automatic rate_run(input longint x, input longint exp, input int lat);
		@(posedge pclk);
		raw_rate <= x[23:0];
		raw_rate_valid <= 1'b1;
		@(posedge pclk);
		raw_rate_valid <= 1'b0;
		n = 1;
		@(negedge pclk);
		while (!rate_out_valid && n < 200) begin
			@(negedge pclk);
			n++;
		end
		chk("rate latency", lat, n);
		chk("rate out", {8'h0, exp[23:0]}, {8'h0, rate_out});
	endtask
	// Bench models with only the constant terms in use
	function automatic longint model_rate(longint x, longint b, longint s);
		return ((x - b) * 134217728) / s;
	endfunction
	function automatic longint model_temp(longint t, longint gg, longint oo);
		return ((t * gg) >>> 11) - oo;
	endfunction
	// Watchdog, far beyond the expected run
	initial begin
		#200000;
		miscompares++;
		end_of_test;
	end
	initial begin
		presetn = 1'b0;
		nvm_por_n = 1'b0;
		raw_rate = 24'h0;
		raw_rate_valid = 1'b0;
		raw_temp = 16'h0;
		void'($urandom(43756));
		repeat (3) @(posedge pclk);
		nvm_por_n <= 1'b1;
		reboot;
		rd_chk(8'h00, RST_CTRL);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h18, RST_SF0);
		rd_chk(8'h34, RST_TCAL);
		req(1'b1, 8'h3c, 32'h1, 1'b1);
		req(1'b0, 8'h48, 32'h0, 1'b1);
		req(1'b1, 8'h01, 32'h1, 1'b1);
		// Temperature path, raw and calibrated in turn
		for (int i = 0; i < 8; i++) begin
			g = $urandom_range(16383);
			o = $urandom_range(16383);
			req(1'b1, 8'h34, {o[13:0], g[13:0], 4'h0}, 1'b0);
			req(1'b1, 8'h00, {30'h0, i[0], 1'b1}, 1'b0);
			@(posedge pclk);
			raw_temp <= 16'($urandom);
			@(posedge pclk);
			@(negedge pclk);
			r = longint'($signed(raw_temp));
			chk("temp out", {16'h0, 16'(i[0] ? model_temp(r, g, o) : r)}, {16'h0, temp_out});
		end
		// Rate path: raw pass, unity scale and double scale
		for (int i = 0; i < 6; i++) begin
			b0 = longint'($urandom_range(2000)) * 2 - 2000;
			r = (longint'($urandom_range(2097152)) - 1048576) & -2;
			sf0 = (i % 3 == 2) ? 268435456 : 134217728;
			req(1'b1, 8'h2c, b0[31:0], 1'b0);
			req(1'b1, 8'h18, sf0[31:0], 1'b0);
			req(1'b1, 8'h00, {31'h0, i % 3 != 0}, 1'b0);
			if (i % 3 == 0)
				rate_run(r, r, 1);
			else
				rate_run(r, model_rate(r, b0, sf0), 85);
		end
		// Commit without counter step leaves the defaults
		host.commit_reg(5'h06, 32'h0c00_0000, err);
		chk("commit", 32'h0, {31'h0, err});
		reboot;
		rd_chk(8'h18, RST_SF0);
		for (int k = 1; k < 6; k++) begin
			for (int i = 0; i < 14; i++)
				v[i] = 32'h0;
			v[0] = 32'h1;
			v[6] = RST_SF0;
			v[11] = 32'(2 * k);
			v[13] = RST_TCAL;
			host.program_all(v, err);
			chk("commit", 32'h0, {31'h0, err});
			req(1'b1, 8'h38, 32'h1, 1'b1);
			host.step_slot(slot, err);
			chk("slot commit", 32'h0, {31'h0, err});
			chk("slot step", (1 << k) - 1, {27'h0, slot});
			reboot;
			rd_chk(8'h04, (1 << k) - 1);
			rd_chk(8'h2c, 2 * k);
			rate_run(r, r - 2 * k, 85);
		end
		req(1'b1, 8'h38, 32'h6, 1'b1);
		req(1'b1, 8'h38, 32'h1, 1'b1);
		end_of_test;
	end
endmodule // rate_temp_compensation_nvm_test
`default_nettype wire
